// ---- mri_pkg.sv ----
// Constants, types and register map of the MAC receive status and interrupt unit.
`default_nettype none
package mri_pkg;
	localparam logic [7:0] OFF_TX_STATUS = 8'h14;
	localparam logic [7:0] OFF_TX_QPTR = 8'h1c;
	localparam logic [7:0] OFF_RX_STATUS = 8'h20;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h28;
	localparam logic [7:0] OFF_IRQ_DISABLE = 8'h2c;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h30;
	localparam logic [7:0] OFF_PAUSE_TIME = 8'h38;

	localparam int RSR_BUF_UNAVAIL_BIT = 0;
	localparam int RSR_FRAME_STORED_BIT = 1;
	localparam int RSR_OVERRUN_BIT = 2;
	localparam int TSR_TX_ACTIVE_BIT = 3;

	localparam int ISR_MGMT_DONE_BIT = 0;
	localparam int ISR_RX_COMPLETE_BIT = 1;
	localparam int ISR_RX_OWNED_BIT = 2;
	localparam int ISR_TX_OWNED_BIT = 3;
	localparam int ISR_TX_UNDERRUN_BIT = 4;
	localparam int ISR_RETRY_LIMIT_BIT = 5;
	localparam int ISR_TX_EXHAUSTED_BIT = 6;
	localparam int ISR_TX_COMPLETE_BIT = 7;
	localparam int ISR_RX_OVERRUN_BIT = 10;
	localparam int ISR_BUS_ERROR_BIT = 11;
	localparam int ISR_PAUSE_FRAME_BIT = 12;
	localparam int ISR_PAUSE_ZERO_BIT = 13;

	localparam logic [31:0] IRQ_SRC_MASK = 32'h0000_3cff;
	localparam logic [31:0] TQP_ADDR_MASK = 32'hffff_fffc;
	localparam logic [2:0] RSR_RESET = 3'h0;
	localparam logic [31:0] ISR_RESET = 32'h0000_0000;
	localparam logic [31:0] MASK_RESET = 32'h0000_3cff;
	localparam logic [31:0] TQP_RESET = 32'h0000_0000;
	localparam int PAUSE_W = 16;
	localparam logic [15:0] PAUSE_RESET = 16'h0000;
	localparam int PAUSE_QUANTUM_BITS = 512;
	localparam int PRESCALE_W = 9;
	localparam logic [8:0] PRESCALE_LAST = 9'(PAUSE_QUANTUM_BITS - 1);

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		REG_NONE, REG_TX_STATUS, REG_TX_QPTR, REG_RX_STATUS, REG_IRQ_STATUS,
		REG_IRQ_ENABLE, REG_IRQ_DISABLE, REG_IRQ_MASK, REG_PAUSE_TIME
	} mri_reg_t;

	typedef enum logic [1:0] {
		RXF_NORMAL = 2'h1,
		RXF_BLOCKED = 2'h2
	} mri_rxf_state_t;

	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
	} mri_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} mri_axi_rsp_t;

	typedef struct packed {
		logic mgmt_done;
		logic rx_frame_stored;
		logic rx_fetch_owned;
		logic tx_owned_desc_read;
		logic tx_underrun;
		logic retry_limit_hit;
		logic tx_buffers_exhausted;
		logic tx_complete;
		logic rx_store_fail;
		logic bus_error;
		logic pause_frame_seen;
	} mri_events_t;
endpackage : mri_pkg
`default_nettype wire

// ---- mri_pause_timer.sv ----
// Pause time counter with a 512 bit time prescaler and a zero event.
`default_nettype none
module mri_pause_timer
	import mri_pkg::*;
(
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// Load and bit time tick.
	input wire logic load_i,
	input wire logic [PAUSE_W-1:0] load_value_i,
	input wire logic bit_tick_i,
	// Count and events.
	output logic [PAUSE_W-1:0] count_o,
	output logic zero_pulse_o,
	output logic active_o
);
	logic [PAUSE_W-1:0] count_q, count_d;
	logic [PRESCALE_W-1:0] pre_q, pre_d;
	logic zero_q, zero_d;

	always_comb begin
		count_d = count_q;
		pre_d = pre_q;
		zero_d = 1'b0;
		if (load_i) begin
			count_d = load_value_i;
			pre_d = '0;
		end else if (count_q != '0 && bit_tick_i) begin
			if (pre_q == PRESCALE_LAST) begin
				pre_d = '0;
				count_d = count_q - 1'b1;
				zero_d = (count_q == PAUSE_W'(1));
			end else begin
				pre_d = pre_q + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			count_q <= PAUSE_RESET;
			pre_q <= '0;
			zero_q <= 1'b0;
		end else begin
			count_q <= count_d;
			pre_q <= pre_d;
			zero_q <= zero_d;
		end
	end

	assign count_o = count_q;
	assign zero_pulse_o = zero_q;
	assign active_o = (count_q != '0);
endmodule : mri_pause_timer
`default_nettype wire

// ---- mri_unit.sv ----
// Receive status, interrupt status and mask registers behind an AXI4-Lite slave.
`default_nettype none
module mri_unit
	import mri_pkg::*;
(
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// Register bus.
	input wire mri_axi_req_t axi_req_i,
	output mri_axi_rsp_t axi_rsp_o,
	// Engine events and state.
	input wire mri_events_t events_i,
	input wire logic tx_active_i,
	input wire logic tx_frame_ptr_load_i,
	input wire logic [31:0] tx_frame_ptr_i,
	input wire logic rx_frame_start_i,
	input wire logic rx_desc_fetch_ok_i,
	input wire logic bit_tick_i,
	input wire logic [PAUSE_W-1:0] pause_frame_value_i,
	// Controls and interrupt.
	output logic irq_o,
	output logic [31:0] tx_queue_start_o,
	output logic tx_queue_start_load_o,
	output logic rx_refetch_desc_o,
	output logic rx_buffer_recover_o,
	output logic pause_active_o
);
	function automatic mri_reg_t reg_decode(input logic [31:0] addr);
		mri_reg_t sel;
		sel = REG_NONE;
		case ({addr[7:2], 2'b00})
			OFF_TX_STATUS: sel = REG_TX_STATUS;
			OFF_TX_QPTR: sel = REG_TX_QPTR;
			OFF_RX_STATUS: sel = REG_RX_STATUS;
			OFF_IRQ_STATUS: sel = REG_IRQ_STATUS;
			OFF_IRQ_ENABLE: sel = REG_IRQ_ENABLE;
			OFF_IRQ_DISABLE: sel = REG_IRQ_DISABLE;
			OFF_IRQ_MASK: sel = REG_IRQ_MASK;
			OFF_PAUSE_TIME: sel = REG_PAUSE_TIME;
			default: sel = REG_NONE;
		endcase
		return sel;
	endfunction : reg_decode

	// Bus channel state.
	logic aw_full_q, aw_full_d;
	logic [31:0] aw_addr_q, aw_addr_d;
	logic w_full_q, w_full_d;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0] w_strb_q, w_strb_d;
	logic b_valid_q, b_valid_d;
	logic [1:0] b_resp_q, b_resp_d;
	logic r_valid_q, r_valid_d;
	logic [31:0] r_data_q, r_data_d;
	logic [1:0] r_resp_q, r_resp_d;

	// Register state.
	logic [31:0] tqp_q, tqp_d;
	logic [2:0] rsr_q, rsr_d;
	logic [31:0] isr_q, isr_d;
	logic [31:0] mask_q, mask_d;
	logic irq_q, irq_d;
	logic tqp_load_q, tqp_load_d;
	logic recover_q, recover_d;
	logic refetch_q, refetch_d;
	mri_rxf_state_t rxf_q, rxf_d;

	// Decode and strobes.
	logic wr_fire, rd_fire;
	mri_reg_t wr_sel, rd_sel;
	logic [31:0] wr_mask, wr_val;
	logic tqp_write, isr_read, pause_load;
	logic [PAUSE_W-1:0] pause_value, pause_count;
	logic pause_zero, pause_active;
	logic [31:0] isr_set;
	logic [2:0] rsr_set;

	assign wr_fire = aw_full_q && w_full_q && !b_valid_q;
	assign rd_fire = axi_req_i.arvalid && !r_valid_q;
	assign wr_sel = reg_decode(aw_addr_q);
	assign rd_sel = reg_decode(axi_req_i.araddr);
	assign wr_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	assign wr_val = w_data_q & wr_mask;
	assign tqp_write = wr_fire && wr_sel == REG_TX_QPTR && !tx_active_i;
	assign isr_read = rd_fire && rd_sel == REG_IRQ_STATUS;
	assign pause_load = (wr_fire && wr_sel == REG_PAUSE_TIME) || events_i.pause_frame_seen;
	assign pause_value = (wr_fire && wr_sel == REG_PAUSE_TIME) ? wr_val[PAUSE_W-1:0]
		: pause_frame_value_i;

	mri_pause_timer u_pause (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.load_i(pause_load),
		.load_value_i(pause_value),
		.bit_tick_i(bit_tick_i),
		.count_o(pause_count),
		.zero_pulse_o(pause_zero),
		.active_o(pause_active)
	);

	// Bus channels.
	always_comb begin
		aw_full_d = aw_full_q;
		aw_addr_d = aw_addr_q;
		w_full_d = w_full_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		b_valid_d = b_valid_q;
		b_resp_d = b_resp_q;
		r_valid_d = r_valid_q;
		r_data_d = r_data_q;
		r_resp_d = r_resp_q;
		if (wr_fire) begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			b_valid_d = 1'b1;
			b_resp_d = (wr_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else begin
			if (axi_req_i.awvalid && !aw_full_q) begin
				aw_full_d = 1'b1;
				aw_addr_d = axi_req_i.awaddr;
			end
			if (axi_req_i.wvalid && !w_full_q) begin
				w_full_d = 1'b1;
				w_data_d = axi_req_i.wdata;
				w_strb_d = axi_req_i.wstrb;
			end
		end
		if (b_valid_q && axi_req_i.bready) begin
			b_valid_d = 1'b0;
		end
		if (r_valid_q && axi_req_i.rready) begin
			r_valid_d = 1'b0;
		end
		if (rd_fire) begin
			r_valid_d = 1'b1;
			r_resp_d = RESP_OKAY;
			case (rd_sel)
				REG_TX_STATUS: r_data_d = 32'(tx_active_i) << TSR_TX_ACTIVE_BIT;
				REG_TX_QPTR: r_data_d = tqp_q;
				REG_RX_STATUS: r_data_d = {29'h0, rsr_q};
				REG_IRQ_STATUS: r_data_d = isr_q;
				REG_IRQ_MASK: r_data_d = mask_q;
				REG_PAUSE_TIME: r_data_d = {16'h0, pause_count};
				REG_IRQ_ENABLE, REG_IRQ_DISABLE: r_data_d = 32'h0000_0000;
				default: begin
					r_data_d = 32'h0000_0000;
					r_resp_d = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 32'h0000_0000;
			w_full_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			b_valid_q <= 1'b0;
			b_resp_q <= RESP_OKAY;
			r_valid_q <= 1'b0;
			r_data_q <= 32'h0000_0000;
			r_resp_q <= RESP_OKAY;
		end else begin
			aw_full_q <= aw_full_d;
			aw_addr_q <= aw_addr_d;
			w_full_q <= w_full_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			b_valid_q <= b_valid_d;
			b_resp_q <= b_resp_d;
			r_valid_q <= r_valid_d;
			r_data_q <= r_data_d;
			r_resp_q <= r_resp_d;
		end
	end

	// Event capture into status.
	always_comb begin
		rsr_set = 3'h0;
		rsr_set[RSR_BUF_UNAVAIL_BIT] = events_i.rx_fetch_owned;
		rsr_set[RSR_FRAME_STORED_BIT] = events_i.rx_frame_stored;
		rsr_set[RSR_OVERRUN_BIT] = events_i.rx_store_fail;
		isr_set = 32'h0000_0000;
		isr_set[ISR_MGMT_DONE_BIT] = events_i.mgmt_done;
		isr_set[ISR_RX_COMPLETE_BIT] = events_i.rx_frame_stored;
		isr_set[ISR_RX_OWNED_BIT] = events_i.rx_fetch_owned;
		isr_set[ISR_TX_OWNED_BIT] = events_i.tx_owned_desc_read;
		isr_set[ISR_TX_UNDERRUN_BIT] = events_i.tx_underrun || tqp_write;
		isr_set[ISR_RETRY_LIMIT_BIT] = events_i.retry_limit_hit;
		isr_set[ISR_TX_EXHAUSTED_BIT] = events_i.tx_buffers_exhausted;
		isr_set[ISR_TX_COMPLETE_BIT] = events_i.tx_complete;
		isr_set[ISR_RX_OVERRUN_BIT] = events_i.rx_store_fail;
		isr_set[ISR_BUS_ERROR_BIT] = events_i.bus_error;
		isr_set[ISR_PAUSE_FRAME_BIT] = events_i.pause_frame_seen;
		isr_set[ISR_PAUSE_ZERO_BIT] = pause_zero;
	end

	// Registers and control outputs.
	always_comb begin
		tqp_d = tqp_q;
		rsr_d = rsr_q | rsr_set;
		isr_d = isr_q;
		mask_d = mask_q;
		tqp_load_d = tqp_write;
		recover_d = events_i.rx_store_fail;
		refetch_d = 1'b0;
		rxf_d = rxf_q;
		if (tqp_write) begin
			tqp_d = wr_val & TQP_ADDR_MASK;
		end else if (tx_frame_ptr_load_i) begin
			tqp_d = tx_frame_ptr_i & TQP_ADDR_MASK;
		end
		if (wr_fire && wr_sel == REG_RX_STATUS) begin
			rsr_d = (rsr_q & ~wr_val[2:0]) | rsr_set;
		end
		if (isr_read) begin
			isr_d = isr_set & IRQ_SRC_MASK;
		end else begin
			isr_d = (isr_q | isr_set) & IRQ_SRC_MASK;
		end
		if (wr_fire && wr_sel == REG_IRQ_ENABLE) begin
			mask_d = mask_q & ~(wr_val & IRQ_SRC_MASK);
		end
		if (wr_fire && wr_sel == REG_IRQ_DISABLE) begin
			mask_d = mask_q | (wr_val & IRQ_SRC_MASK);
		end
		irq_d = |(isr_q & ~mask_q & IRQ_SRC_MASK);
		case (rxf_q)
			RXF_NORMAL: begin
				if (events_i.rx_fetch_owned) begin
					rxf_d = RXF_BLOCKED;
				end
			end
			RXF_BLOCKED: begin
				if (rx_desc_fetch_ok_i) begin
					rxf_d = RXF_NORMAL;
				end else if (rx_frame_start_i) begin
					refetch_d = 1'b1;
				end
			end
			default: rxf_d = RXF_NORMAL;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			tqp_q <= TQP_RESET;
			rsr_q <= RSR_RESET;
			isr_q <= ISR_RESET;
			mask_q <= MASK_RESET;
			irq_q <= 1'b0;
			tqp_load_q <= 1'b0;
			recover_q <= 1'b0;
			refetch_q <= 1'b0;
			rxf_q <= RXF_NORMAL;
		end else begin
			tqp_q <= tqp_d;
			rsr_q <= rsr_d;
			isr_q <= isr_d;
			mask_q <= mask_d;
			irq_q <= irq_d;
			tqp_load_q <= tqp_load_d;
			recover_q <= recover_d;
			refetch_q <= refetch_d;
			rxf_q <= rxf_d;
		end
	end

	assign axi_rsp_o.awready = !aw_full_q;
	assign axi_rsp_o.wready = !w_full_q;
	assign axi_rsp_o.bvalid = b_valid_q;
	assign axi_rsp_o.bresp = b_resp_q;
	assign axi_rsp_o.arready = !r_valid_q;
	assign axi_rsp_o.rvalid = r_valid_q;
	assign axi_rsp_o.rdata = r_data_q;
	assign axi_rsp_o.rresp = r_resp_q;
	assign irq_o = irq_q;
	assign tx_queue_start_o = tqp_q;
	assign tx_queue_start_load_o = tqp_load_q;
	assign rx_refetch_desc_o = refetch_q;
	assign rx_buffer_recover_o = recover_q;
	assign pause_active_o = pause_active;
endmodule : mri_unit
`default_nettype wire

// ---- mri_unit_checker.sv ----
// Concurrent checks on the ports of the receive status and interrupt unit.
`default_nettype none
module mri_unit_checker
	import mri_pkg::*;
(
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// Watched ports.
	input wire mri_axi_req_t axi_req_i,
	input wire mri_axi_rsp_t axi_rsp_o,
	input wire mri_events_t events_i,
	input wire logic tx_frame_ptr_load_i,
	input wire logic [31:0] tx_frame_ptr_i,
	input wire logic rx_frame_start_i,
	input wire logic bit_tick_i,
	input wire logic [PAUSE_W-1:0] pause_frame_value_i,
	input wire logic [31:0] tx_queue_start_o,
	input wire logic rx_refetch_desc_o,
	input wire logic rx_buffer_recover_o,
	input wire logic pause_active_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);
	sequence s_rd_take;
		axi_req_i.arvalid && axi_rsp_o.arready;
	endsequence
	sequence s_rd_wait;
		axi_rsp_o.rvalid && !axi_req_i.rready;
	endsequence
	a_read_answer: assert property (s_rd_take |=> axi_rsp_o.rvalid)
		else $error("read not answered");
	a_read_hold: assert property (s_rd_wait |=> axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata))
		else $error("read answer dropped");
	a_recover_pulse: assert property (events_i.rx_store_fail |=> rx_buffer_recover_o)
		else $error("buffer not recovered");
	a_recover_cause: assert property (rx_buffer_recover_o |-> $past(events_i.rx_store_fail))
		else $error("recover without overrun");
	a_refetch_cause: assert property (rx_refetch_desc_o |-> $past(rx_frame_start_i))
		else $error("refetch without frame start");
	a_pause_start: assert property (events_i.pause_frame_seen && pause_frame_value_i != '0
		&& axi_rsp_o.awready |=> pause_active_o)
		else $error("pause not started");
	a_pause_hold: assert property (pause_active_o && !bit_tick_i && axi_rsp_o.awready
		&& !events_i.pause_frame_seen |=> pause_active_o)
		else $error("pause ended without ticks");
	a_qptr_load: assert property (tx_frame_ptr_load_i && axi_rsp_o.awready
		|=> tx_queue_start_o == ($past(tx_frame_ptr_i) & TQP_ADDR_MASK))
		else $error("queue pointer not loaded");
endmodule : mri_unit_checker
bind mri_unit mri_unit_checker u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .axi_req_i(axi_req_i),
	.axi_rsp_o(axi_rsp_o), .events_i(events_i), .tx_frame_ptr_load_i(tx_frame_ptr_load_i),
	.tx_frame_ptr_i(tx_frame_ptr_i), .rx_frame_start_i(rx_frame_start_i),
	.bit_tick_i(bit_tick_i), .pause_frame_value_i(pause_frame_value_i),
	.tx_queue_start_o(tx_queue_start_o), .rx_refetch_desc_o(rx_refetch_desc_o),
	.rx_buffer_recover_o(rx_buffer_recover_o), .pause_active_o(pause_active_o));
`default_nettype wire

// ---- mri_engine_model.sv ----
// Engine side model that drives bench commands onto the event, frame start and fetch ok outputs one cycle later.
`default_nettype none
module mri_engine_model
	import mri_pkg::*;
(
	// Clock.
	input wire logic mclk_i,
	// Commands from the bench.
	input wire logic [12:0] cmd_i,
	// Pulses to the unit.
	output mri_events_t events_o,
	output logic frame_start_o,
	output logic fetch_ok_o
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge mclk_i) begin
		{events_o, frame_start_o, fetch_ok_o} <= cmd_i;
	end
endmodule : mri_engine_model
`default_nettype wire

// ---- mri_unit_tb_top.sv ----
// Self-checking testbench of the receive status and interrupt unit.
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module mri_unit_tb_top
	import mri_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, rst_b, tick, tx_act, ptr_ld, fs, fok, irq, rf, ldp;
	logic [31:0] ptr, rdat, v, m, e, d;
	logic [1:0] rrsp;
	logic [12:0] cmd;
	logic [15:0] pval;
	mri_axi_req_t req;
	mri_axi_rsp_t rsp;
	mri_events_t ev;
	int fail_count, total_checks, rf_cnt, ld_cnt;
	int bits[11] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 11, 12};
	mri_engine_model u_eng (.mclk_i(mclk), .cmd_i(cmd), .events_o(ev), .frame_start_o(fs),
		.fetch_ok_o(fok));
	mri_unit DUT (.mclk_i(mclk), .rst_b_i(rst_b), .axi_req_i(req), .axi_rsp_o(rsp),
		.events_i(ev), .tx_active_i(tx_act), .tx_frame_ptr_load_i(ptr_ld),
		.tx_frame_ptr_i(ptr), .rx_frame_start_i(fs), .rx_desc_fetch_ok_i(fok),
		.bit_tick_i(tick), .pause_frame_value_i(pval), .irq_o(irq), .tx_queue_start_o(),
		.tx_queue_start_load_o(ldp), .rx_refetch_desc_o(rf), .rx_buffer_recover_o(),
		.pause_active_o());
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (rf === 1'b1) rf_cnt++;
		if (ldp === 1'b1) ld_cnt++;
	end
	function automatic logic [31:0] mexp(input logic [31:0] cur, en, dis);
		return (cur & ~(en & IRQ_SRC_MASK)) | (dis & IRQ_SRC_MASK);
	endfunction : mexp
	task automatic wr(input logic [7:0] a, input logic [31:0] dt);
		@(posedge mclk);
		req.awvalid <= 1'b1;
		req.awaddr <= {24'h0, a};
		req.wvalid <= 1'b1;
		req.wdata <= dt;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid) break;
		end
		rrsp = rsp.bresp;
		req.bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input int lag = 0);
		@(posedge mclk);
		req.arvalid <= 1'b1;
		req.araddr <= {24'h0, a};
		req.rready <= (lag == 0);
		forever begin
			@(posedge mclk);
			if (rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid && req.rready) break;
			if (lag > 0) lag--;
			else if (!req.rready) req.rready <= 1'b1;
		end
		rdat = rsp.rdata;
		rrsp = rsp.rresp;
		req.rready <= 1'b0;
	endtask : rd
	task automatic pulse(input logic [12:0] c);
		@(posedge mclk);
		cmd <= c;
		@(posedge mclk);
		cmd <= '0;
		repeat (3) @(posedge mclk);
	endtask : pulse
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		wrap_up();
	end
	initial begin
		void'($urandom(75));
		rst_b = 1'b0;
		req = '0;
		cmd = '0;
		tick = 1'b0;
		tx_act = 1'b0;
		ptr_ld = 1'b0;
		ptr = '0;
		pval = 16'($urandom) | 16'h0001;
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		rd(OFF_IRQ_MASK, 1 + $urandom % 4);
		`CHK(rdat, MASK_RESET)
		rd(8'h34);
		`CHK(rrsp, RESP_SLVERR)
		wr(8'h34, '1);
		`CHK(rrsp, RESP_SLVERR)
		m = MASK_RESET;
		for (int i = 0; i < 4; i++) begin
			e = (i == 0) ? 32'h0 : $urandom;
			d = $urandom;
			wr(OFF_IRQ_ENABLE, e);
			m = mexp(m, e, '0);
			rd(OFF_IRQ_MASK);
			`CHK(rdat, m)
			wr(OFF_IRQ_DISABLE, d);
			m = mexp(m, '0, d);
			rd(OFF_IRQ_MASK);
			`CHK(rdat, m)
		end
		wr(OFF_IRQ_ENABLE, IRQ_SRC_MASK);
		for (int i = 0; i < 11; i++) begin
			pulse(13'h1 << (12 - i));
			`CHK(irq, 1'b1)
			rd(OFF_IRQ_STATUS);
			`CHK(rdat[bits[i]], 1'b1)
			rd(OFF_IRQ_STATUS);
			`CHK(rdat, 32'h0)
			`CHK(irq, 1'b0)
		end
		wr(OFF_IRQ_DISABLE, IRQ_SRC_MASK);
		pulse(13'h1 << 5);
		`CHK(irq, 1'b0)
		rd(OFF_IRQ_STATUS);
		rd(OFF_RX_STATUS);
		`CHK(rdat, 32'h7)
		wr(OFF_RX_STATUS, 32'h2);
		rd(OFF_RX_STATUS);
		`CHK(rdat, 32'h5)
		wr(OFF_RX_STATUS, 32'h0);
		rd(OFF_RX_STATUS);
		`CHK(rdat, 32'h5)
		wr(OFF_RX_STATUS, 32'h7);
		rd(OFF_RX_STATUS);
		`CHK(rdat, 32'h0)
		rf_cnt = 0;
		pulse(13'h2);
		`CHK(rf_cnt, 1)
		pulse(13'h2);
		`CHK(rf_cnt, 2)
		pulse(13'h1);
		pulse(13'h2);
		`CHK(rf_cnt, 2)
		pulse(13'h1 << 10);
		wr(OFF_RX_STATUS, 32'h1);
		pulse(13'h1 << 10);
		rd(OFF_RX_STATUS);
		`CHK(rdat, 32'h1)
		v = $urandom;
		ld_cnt = 0;
		rd(OFF_IRQ_STATUS);
		rd(OFF_TX_STATUS);
		`CHK(rdat, 32'h0)
		wr(OFF_TX_QPTR, v);
		rd(OFF_TX_QPTR);
		`CHK(rdat, v & TQP_ADDR_MASK)
		rd(OFF_IRQ_STATUS);
		`CHK(rdat[4], 1'b1)
		tx_act <= 1'b1;
		rd(OFF_TX_STATUS);
		`CHK(rdat, 32'h1 << TSR_TX_ACTIVE_BIT)
		wr(OFF_TX_QPTR, ~v);
		rd(OFF_TX_QPTR);
		`CHK(rdat, v & TQP_ADDR_MASK)
		`CHK(ld_cnt, 1)
		ptr <= $urandom;
		ptr_ld <= 1'b1;
		@(posedge mclk);
		ptr_ld <= 1'b0;
		rd(OFF_TX_QPTR);
		`CHK(rdat, ptr & TQP_ADDR_MASK)
		tx_act <= 1'b0;
		wr(OFF_PAUSE_TIME, 32'h1);
		tick <= 1'b1;
		repeat (400) @(posedge mclk);
		rd(OFF_PAUSE_TIME);
		`CHK(rdat, 32'h1)
		repeat (150) @(posedge mclk);
		rd(OFF_PAUSE_TIME);
		`CHK(rdat, 32'h0)
		rd(OFF_IRQ_STATUS);
		`CHK(rdat[13], 1'b1)
		tick <= 1'b0;
		wrap_up();
	end
endmodule : mri_unit_tb_top
`default_nettype wire
